//--- include/rx_timing_cfg.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * receive timing configuration bank.
 * Assumes it is included by bare name after the types package.
 */
// Notes on behaviour
// R01: modulation bit 7 picks FSK when 0, ASK when 1; no effect in full duplex.
// R02: five-bit sleep count sets sleep as count x 1024 decoder clocks x multiplier.
// R03: sleep extend bit gives sleep multiplier 1 when clear, 8 when set.
// R04: limit extend bit gives limit multiplier 1 or 2, scaling both limit times.
// R05: bit-check code 0..3 checks 0, 3, 6 or 9 bits in receive.
// R06: minimum limit time is field value times extended decoder clock period.
// R07: host keeps minimum limit at 10 or more, maximum limit at 12 or more.
// R08: maximum limit time is field value minus one times extended period.
// R09: bit-rate range gives extended period factor 8, 4, 2, 1 times limit multiplier.
// R10: with range 1, full duplex bit rate is one per 168 decoder clocks.
// R11: host avoids range 3 when receiving ASK; receiver stops above 10 kbit/s.
`ifndef RX_TIMING_CFG_SVH
`define RX_TIMING_CFG_SVH

// ----------------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define IDX_MOD_SLEEP      4'h3
`define IDX_BITCHECK_COUNT_MIN     4'h4
`define IDX_RATE_MAX       4'h5
`define IDX_STATUS         4'h6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_MOD_SLEEP      8'h60
`define RST_BITCHECK_COUNT_MIN     8'h4b
`define RST_RATE_MAX       8'ha0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define F_MOD_SEL          7
`define F_SLEEP_HI         6
`define F_SLEEP_LO         2
`define F_SLEEP_EXT        1
`define F_LIM_EXT          0
`define F_CODE_HI          7
`define F_CODE_LO          6
`define F_LIM_HI           5
`define F_LIM_LO           0

// ----------------------------------------------------------------------
// timing counts, in decoder clock periods unless noted
// ----------------------------------------------------------------------
`define SLEEP_UNIT_DCLK    1024
`define SLEEP_EXT_SHIFT    3
`define FD_BIT_DCLK        8'd168
`define DCLK_DIV_CORE      8'd4
`define LIM_MIN_FLOOR      6'd10
`define LIM_MAX_FLOOR      6'd12
`define RANGE_FD_FIXED     2'd1
`define RANGE_FASTEST      2'd3

`endif

//--- include/rx_timing_pkg.sv
/*
 * Types shared by the receive timing configuration bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rx_timing_pkg;

  // transceiver operating mode, driven by the mode sequencer
  typedef enum logic [2:0] {
    mode_idle,
    mode_rx,
    mode_tx,
    mode_fd_master,
    mode_fd_slave
  } op_mode_t;

  typedef enum logic {
    sleep_idle,
    sleep_run
  } sleep_state_t;

endpackage : rx_timing_pkg

//--- hw/tick_divider.sv
/*
 * Counts step pulses and emits a one-cycle tick every period steps.
 * Assumes step and run come from logic on core_clk.
 */
`timescale 1ns/1ps
module tick_divider (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       step,
  input  wire logic       run,
  input  wire logic [7:0] period,
  output logic            tick
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] last_count;
  logic       wrap;

  // a zero period behaves as one so the tick never stalls
  assign last_count = (period == 8'h00) ? 8'h00 : period - 8'h01;
  assign wrap       = step && (count_reg >= last_count);
  assign count_next = !run ? 8'h00 :
                      wrap ? 8'h00 :
                      step ? count_reg + 8'h01 : count_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_reg <= 8'h00;
      tick      <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick      <= run && wrap;
    end
  end
endmodule : tick_divider

//--- hw/sleep_timer.sv
/*
 * Polling sleep timer: counts decoder clock ticks down from a total.
 * Assumes start and step are single-cycle pulses on core_clk; abort is held as a level.
 */
`timescale 1ns/1ps
module sleep_timer
  import rx_timing_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic        step,
  input  wire logic [17:0] total,
  output logic             busy,
  output logic             done
);
  sleep_state_t state_reg;
  logic [17:0]  left_reg;

  assign busy = (state_reg == sleep_run);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= sleep_idle;
      left_reg  <= 18'h00000;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        sleep_idle: begin
          // a zero total ends at once rather than sleeping forever
          if (start && !abort) begin
            if (total == 18'h00000) begin
              done <= 1'b1;
            end else begin
              left_reg  <= total;
              state_reg <= sleep_run;
            end
          end
        end
        sleep_run: begin
          if (abort) begin
            state_reg <= sleep_idle;
          end else if (step) begin
            left_reg <= left_reg - 18'h00001;
            if (left_reg == 18'h00001) begin
              done      <= 1'b1;
              state_reg <= sleep_idle;
            end
          end
        end
      endcase
    end
  end
endmodule : sleep_timer

//--- hw/rx_timing_config_registers.sv
/*
 * Receive timing configuration bank: three byte-wide control registers
 * behind an APB slave, plus the timing they derive: decoder clock tick,
 * extended decoder clock tick, full duplex bit tick, limit times,
 * bit-check length and the polling sleep timer.
 * Assumes mode and sleep_start come from the mode sequencer on core_clk,
 * and an APB master on core_clk.
 */
`timescale 1ns/1ps
`include "rx_timing_cfg.svh"
module rx_timing_config_registers
  import rx_timing_pkg::*;
#(
  parameter int unsigned SLEEP_UNIT = `SLEEP_UNIT_DCLK,
  parameter logic [7:0]  DCLK_DIV   = `DCLK_DIV_CORE
)(
  input  wire logic        core_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // sequencer side
  input  wire op_mode_t    mode,
  input  wire logic        sleep_start,
  // derived settings
  output logic             ask_mode,
  output logic [3:0]       bitcheck_bits,
  output logic             bitcheck_active,
  output logic [4:0]       xdclk_factor,
  output logic [9:0]       lim_min_dclk,
  output logic [9:0]       lim_max_dclk,
  output logic             limits_active,
  output logic [17:0]      sleep_dclk,
  // timing
  output logic             dclk_tick,
  output logic             xdclk_tick,
  output logic             fd_bit_tick,
  output logic             sleep_busy,
  output logic             sleep_done
);

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------
  function automatic logic hits(input logic [7:0] addr,
                                input logic [3:0] idx);
    hits = (addr == {2'b00, idx, 2'b00});
  endfunction : hits

  // bit-check length for a two-bit code
  function automatic logic [3:0] check_len(input logic [1:0] code);
    unique case (code)
      2'd0: check_len = 4'd0;
      2'd1: check_len = 4'd3;
      2'd2: check_len = 4'd6;
      2'd3: check_len = 4'd9;
    endcase
  endfunction : check_len

  // extended decoder clock period in decoder clock periods
  function automatic logic [4:0] rate_factor(input logic [1:0] range,
                                             input logic       lim_ext);
    logic [4:0] base;
    base = 5'd1;
    unique case (range)
      2'd0: base = 5'd8;
      2'd1: base = 5'd4;
      2'd2: base = 5'd2;
      2'd3: base = 5'd1;
    endcase
    rate_factor = lim_ext ? {base[3:0], 1'b0} : base;
  endfunction : rate_factor

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [7:0]  mod_sleep_reg;
  logic [7:0]  bitcheck_count_min_reg;
  logic [7:0]  rate_max_reg;
  logic [7:0]  mod_sleep_next;
  logic [7:0]  bitcheck_count_min_next;
  logic [7:0]  rate_max_next;
  logic [7:0]  status_val;
  logic [7:0]  read_val;
  logic [31:0] prdata_next;

  // --------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------
  wire hit_mod    = hits(paddr, `IDX_MOD_SLEEP);
  wire hit_min    = hits(paddr, `IDX_BITCHECK_COUNT_MIN);
  wire hit_max    = hits(paddr, `IDX_RATE_MAX);
  wire hit_status = hits(paddr, `IDX_STATUS);
  wire hit_rw     = hit_mod || hit_min || hit_max;
  wire mapped     = hit_rw || hit_status;
  wire setup      = psel && !penable;
  wire access     = psel && penable;
  // status is read only; a write to it is refused like a hole
  wire bad_access = !mapped || (pwrite && hit_status);
  wire wr_commit  = access && pwrite && !bad_access && pstrb[0];

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access && bad_access;

  assign mod_sleep_next  = (wr_commit && hit_mod) ?
                           pwdata[7:0] : mod_sleep_reg;
  assign bitcheck_count_min_next = (wr_commit && hit_min) ?
                           pwdata[7:0] : bitcheck_count_min_reg;
  assign rate_max_next   = (wr_commit && hit_max) ?
                           pwdata[7:0] : rate_max_reg;

  assign read_val = hit_mod    ? mod_sleep_reg  :
                    hit_min    ? bitcheck_count_min_reg :
                    hit_max    ? rate_max_reg   :
                    hit_status ? status_val     : 8'h00;
  // read data is caught in the setup cycle and held through access
  assign prdata_next = setup ? {24'h000000, read_val} : prdata;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mod_sleep_reg  <= `RST_MOD_SLEEP;
      bitcheck_count_min_reg <= `RST_BITCHECK_COUNT_MIN;
      rate_max_reg   <= `RST_RATE_MAX;
      prdata         <= 32'h00000000;
    end else begin
      mod_sleep_reg  <= mod_sleep_next;
      bitcheck_count_min_reg <= bitcheck_count_min_next;
      rate_max_reg   <= rate_max_next;
      prdata         <= prdata_next;
    end
  end

  // --------------------------------------------------------------------
  // field extraction and mode qualification
  // --------------------------------------------------------------------
  wire       mod_sel    = mod_sleep_reg[`F_MOD_SEL];
  wire [4:0] sleep_cnt  = mod_sleep_reg[`F_SLEEP_HI:`F_SLEEP_LO];
  wire       sleep_ext  = mod_sleep_reg[`F_SLEEP_EXT];
  wire       limit_ext  = mod_sleep_reg[`F_LIM_EXT];
  wire [1:0] check_code = bitcheck_count_min_reg[`F_CODE_HI:`F_CODE_LO];
  wire [5:0] lim_min    = bitcheck_count_min_reg[`F_LIM_HI:`F_LIM_LO];
  wire [1:0] rate_range = rate_max_reg[`F_CODE_HI:`F_CODE_LO];
  wire [5:0] lim_max    = rate_max_reg[`F_LIM_HI:`F_LIM_LO];

  wire in_rx      = (mode == mode_rx);
  wire in_fd      = (mode == mode_fd_master) || (mode == mode_fd_slave);
  wire limit_mode = in_rx || (mode == mode_fd_slave);
  wire check_mode = in_rx || (mode == mode_fd_slave);

  // limit multiplier only counts where the limits are used
  wire       lim_ext_eff = limit_ext && limit_mode;               // [R04]
  wire [4:0] factor_val  = rate_factor(rate_range, lim_ext_eff);  // [R09]

  // --------------------------------------------------------------------
  // derived settings
  // --------------------------------------------------------------------
  logic        ask_next;
  logic [3:0]  check_next;
  logic [9:0]  min_next;
  logic [9:0]  max_next;
  logic [17:0] sleep_base;
  logic [17:0] sleep_next;
  logic [5:0]  max_less_one;

  // modulation holds its last meaning in full duplex: no effect there
  assign ask_next   = in_fd ? ask_mode : mod_sel;                 // [R01]
  assign check_next = check_len(check_code);                      // [R05]
  assign min_next   = 10'(lim_min) * 10'(factor_val);             // [R06]
  // a zero field would wrap; clamp since such values are unsupported
  assign max_less_one = (lim_max == 6'h00) ? 6'h00 :
                        lim_max - 6'h01;
  assign max_next   = 10'(max_less_one) * 10'(factor_val);        // [R08]
  assign sleep_base = 18'(sleep_cnt) * 18'(SLEEP_UNIT);           // [R02]
  assign sleep_next = sleep_ext ?                                 // [R03]
                      18'(sleep_base << `SLEEP_EXT_SHIFT) : sleep_base;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ask_mode        <= 1'b0;
      bitcheck_bits   <= 4'd3;
      bitcheck_active <= 1'b0;
      xdclk_factor    <= 5'd2;
      lim_min_dclk    <= 10'd22;
      lim_max_dclk    <= 10'd62;
      limits_active   <= 1'b0;
      sleep_dclk      <= 18'h00000;
    end else begin
      ask_mode        <= ask_next;
      bitcheck_bits   <= check_next;
      bitcheck_active <= check_mode;
      xdclk_factor    <= factor_val;
      lim_min_dclk    <= min_next;
      lim_max_dclk    <= max_next;
      limits_active   <= limit_mode;
      sleep_dclk      <= sleep_next;
    end
  end

  // --------------------------------------------------------------------
  // clock ticks
  // --------------------------------------------------------------------
  // decoder clock derived from core_clk; divider is a plain default
  tick_divider u_dclk (
    .core_clk (core_clk),
    .reset    (reset),
    .step     (1'b1),
    .run      (1'b1),
    .period   (DCLK_DIV),
    .tick     (dclk_tick)
  );

  tick_divider u_xdclk (
    .core_clk (core_clk),
    .reset    (reset),
    .step     (dclk_tick),
    .run      (1'b1),
    .period   ({3'b000, factor_val}),                             // [R09]
    .tick     (xdclk_tick)
  );

  // only range 1 fixes the full duplex rate; other ranges leave it off
  wire fd_fixed_run = in_fd && (rate_range == `RANGE_FD_FIXED);

  tick_divider u_fd_bit (
    .core_clk (core_clk),
    .reset    (reset),
    .step     (dclk_tick),
    .run      (fd_fixed_run),
    .period   (`FD_BIT_DCLK),                                     // [R10]
    .tick     (fd_bit_tick)
  );

  // --------------------------------------------------------------------
  // polling sleep
  // --------------------------------------------------------------------
  // sleep settings mean nothing outside receive, so leaving it aborts
  wire sleep_go    = sleep_start && in_rx;                        // [R02]
  wire sleep_abort = !in_rx;

  sleep_timer u_sleep (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (sleep_go),
    .abort    (sleep_abort),
    .step     (dclk_tick),
    .total    (sleep_next),
    .busy     (sleep_busy),
    .done     (sleep_done)
  );

  // --------------------------------------------------------------------
  // status, read only
  // --------------------------------------------------------------------
  // flags values the host must not program; the logic still runs
  wire min_low  = (lim_min < `LIM_MIN_FLOOR);                     // [R07]
  wire max_low  = (lim_max < `LIM_MAX_FLOOR);                     // [R07]
  wire ask_fast = mod_sel && (rate_range == `RANGE_FASTEST);      // [R11]

  assign status_val = {3'b000, ask_fast, max_low, min_low,
                       limit_mode, sleep_busy};

endmodule : rx_timing_config_registers

//--- dv/rx_timing_asserts.sv
/*
 * Port checker for the receive timing configuration bank.
 * Assumes it is bound onto rx_timing_config_registers, one clock domain.
 */
`timescale 1ns/1ps
module rx_timing_checker
  import rx_timing_pkg::*;
#(
  parameter int unsigned SLEEP_UNIT = 1024,
  parameter logic [7:0]  DCLK_DIV   = 8'h04
)(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire op_mode_t    mode,
  input wire logic        sleep_start,
  input wire logic        ask_mode,
  input wire logic [3:0]  bitcheck_bits,
  input wire logic [4:0]  xdclk_factor,
  input wire logic [17:0] sleep_dclk,
  input wire logic        fd_bit_tick,
  input wire logic        sleep_busy,
  input wire logic        sleep_done
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire acc = psel && penable;
  wire mapped = paddr inside {8'h0c, 8'h10, 8'h14, 8'h18};
  wire in_fd = mode inside {mode_fd_master, mode_fd_slave};
  // gap counter restarts when full duplex is left, so mode hops are safe
  logic [15:0] gap_cnt;
  logic        gap_seen;
  always_ff @(posedge core_clk) begin
    if (reset || !in_fd) begin
      gap_cnt  <= 16'h0;
      gap_seen <= 1'b0;
    end else if (fd_bit_tick) begin
      gap_cnt  <= 16'h1;
      gap_seen <= 1'b1;
    end else begin
      gap_cnt  <= gap_cnt + 16'h1;
    end
  end
  sequence s_start;
    sleep_start && mode == mode_rx && !sleep_busy && sleep_dclk != 18'h0;
  endsequence
  sequence s_finish;
    sleep_done && !sleep_busy ##1 !sleep_done;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (acc && mapped && paddr != 8'h18 |-> !pslverr)
    else $error("mapped access flagged as error");
  a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 0)
    else $error("unmapped read returned data");
  a_bitcheck_code: assert property (bitcheck_bits inside {0, 3, 6, 9})
    else $error("bit-check length outside 0/3/6/9");
  a_factor_code: assert property (xdclk_factor inside {1, 2, 4, 8, 16})
    else $error("extended period factor illegal");
  a_fd_only: assert property (fd_bit_tick |-> $past(in_fd))
    else $error("full duplex bit tick outside full duplex");
  a_fd_gap: assert property (fd_bit_tick && gap_seen |->
    gap_cnt == 16'(168 * DCLK_DIV))
    else $error("full duplex bit period wrong");
  a_ask_frozen: assert property (in_fd && $past(in_fd) |->
    $stable(ask_mode))
    else $error("modulation select moved in full duplex");
  a_sleep_go: assert property (s_start |=> sleep_busy || sleep_done)
    else $error("sleep did not start");
  a_done_pulse: assert property (sleep_done |-> s_finish)
    else $error("sleep done not a single pulse");
endmodule : rx_timing_checker

bind rx_timing_config_registers rx_timing_checker #(
  .SLEEP_UNIT(SLEEP_UNIT),
  .DCLK_DIV  (DCLK_DIV)
) chk (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .mode(mode), .sleep_start(sleep_start), .ask_mode(ask_mode),
  .bitcheck_bits(bitcheck_bits), .xdclk_factor(xdclk_factor),
  .sleep_dclk(sleep_dclk), .fd_bit_tick(fd_bit_tick),
  .sleep_busy(sleep_busy), .sleep_done(sleep_done)
);

//--- dv/test_rx_timing_config_registers.sv
/*
 * Self-checking bench of the receive timing configuration bank.
 * Assumes shortened counts: SLEEP_UNIT 2, decoder tick every core clock.
 */
`timescale 1ns/1ps
`include "rx_timing_cfg.svh"
module test_rx_timing_config_registers;
  import rx_timing_pkg::*;
  // ----------------------------------------------------------------
  // signals and table
  // ----------------------------------------------------------------
  localparam logic [7:0] A_MOD = {2'b00, `IDX_MOD_SLEEP, 2'b00};
  localparam logic [7:0] A_BIT = {2'b00, `IDX_BITCHECK_COUNT_MIN, 2'b00};
  localparam logic [7:0] A_RAT = {2'b00, `IDX_RATE_MAX, 2'b00};
  logic core_clk, reset, psel, penable, pwrite, sleep_start, err;
  logic pready, pslverr, ask_mode, bc_act, limits_active;
  logic dclk_tick, xdclk_tick, fd_bit_tick, sleep_busy, sleep_done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, bitcheck_bits;
  logic [4:0]  xdclk_factor;
  logic [9:0]  lim_min_dclk, lim_max_dclk;
  logic [17:0] sleep_dclk;
  op_mode_t    mode;
  int          miscompares, cmp_count, n, xn, dn;
  typedef struct {
    logic [7:0] m, b, r; op_mode_t md; logic ask; logic [3:0] bits;
    logic [4:0] fac; logic [9:0] mn, mx; logic [17:0] slp; logic act;
  } row_t;
  // limits stay at or above floors, ask never meets range 3 in rx
  row_t rows [6] = '{
    '{8'h60, 8'h4b, 8'ha0, mode_rx, 0, 3, 2, 22, 62, 48, 1},
    '{8'h83, 8'h0a, 8'h0c, mode_rx, 1, 0, 16, 160, 176, 0, 1},
    '{8'h7e, 8'hbf, 8'h7f, mode_rx, 0, 6, 4, 252, 248, 496, 1},
    '{8'h05, 8'hcc, 8'hcd, mode_fd_slave, 0, 9, 2, 24, 24, 2, 1},
    '{8'h85, 8'hcc, 8'hcd, mode_tx, 1, 9, 1, 12, 12, 2, 0},
    '{8'h05, 8'hcc, 8'hcd, mode_fd_master, 1, 9, 1, 12, 12, 2, 0}};

  rx_timing_config_registers #(.SLEEP_UNIT(2), .DCLK_DIV(8'h01)) dut (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
    .sleep_start(sleep_start), .ask_mode(ask_mode),
    .bitcheck_bits(bitcheck_bits), .bitcheck_active(bc_act),
    .xdclk_factor(xdclk_factor), .lim_min_dclk(lim_min_dclk),
    .lim_max_dclk(lim_max_dclk), .limits_active(limits_active),
    .sleep_dclk(sleep_dclk), .dclk_tick(dclk_tick),
    .xdclk_tick(xdclk_tick), .fd_bit_tick(fd_bit_tick),
    .sleep_busy(sleep_busy), .sleep_done(sleep_done));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // one transfer, then an idle edge so strobes never toggle twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, {24'h0, e}, rd);
    chk("read_err", 0, err);
  endtask : rdchk

  task automatic wait_fd(input int lim);
    while (fd_bit_tick !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_fd

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    #(40 * 8000);
    miscompares++;
    conclude();
  end

  initial begin
    reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'hf; mode = mode_idle; sleep_start = 0;
    miscompares = 0; cmp_count = 0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rdchk("mod_rst", A_MOD, `RST_MOD_SLEEP);
    rdchk("bit_rst", A_BIT, `RST_BITCHECK_COUNT_MIN);
    rdchk("rat_rst", A_RAT, `RST_RATE_MAX);
    foreach (rows[i]) begin
      mode <= rows[i].md;
      apb(1'b1, A_MOD, {24'h0, rows[i].m});
      apb(1'b1, A_BIT, {24'h0, rows[i].b});
      apb(1'b1, A_RAT, {24'h0, rows[i].r});
      repeat (2) @(posedge core_clk);
      chk("ask_mode", rows[i].ask, ask_mode);
      chk("bits", rows[i].bits, bitcheck_bits);
      chk("factor", rows[i].fac, xdclk_factor);
      chk("lim_min", rows[i].mn, lim_min_dclk);
      chk("lim_max", rows[i].mx, lim_max_dclk);
      chk("sleep", rows[i].slp, sleep_dclk);
      chk("lim_act", rows[i].act, limits_active);
      chk("bc_act", rows[i].act, bc_act);
      rdchk("mod_rb", A_MOD, rows[i].m);
    end
    // refused accesses and masked writes leave the bank alone
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, rd);
    apb(1'b1, 8'h18, 32'hff);
    chk("status_wr_err", 1, err);
    pstrb <= 4'h0;
    apb(1'b1, A_BIT, 32'h33);
    pstrb <= 4'hf;
    rdchk("strobe_off", A_BIT, 8'hcc);
    apb(1'b1, A_BIT, 32'hffffff8b);
    rdchk("upper_bits", A_BIT, 8'h8b);
    // sleep run: count 3, unit 2, so six decoder ticks
    mode <= mode_rx;
    apb(1'b1, A_MOD, 32'h0c);
    repeat (2) @(posedge core_clk);
    chk("sleep_3", 6, sleep_dclk);
    rdchk("status", 8'h18, 8'h02);
    sleep_start <= 1'b1;
    @(posedge core_clk);
    sleep_start <= 1'b0;
    n = 0;
    while (sleep_done !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    chk("sleep_len", 1, n >= 6 && n <= 9);
    mode <= mode_tx;
    @(posedge core_clk);
    sleep_start <= 1'b1;
    @(posedge core_clk);
    sleep_start <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("tx_no_sleep", 0, sleep_busy);
    // full duplex bit period in range 1, none in range 2
    mode <= mode_idle;
    apb(1'b1, A_RAT, 32'h60);
    mode <= mode_fd_master;
    n = 0;
    wait_fd(400);
    @(posedge core_clk);
    n = 1;
    wait_fd(400);
    chk("fd_gap", 168, n);
    mode <= mode_idle;
    apb(1'b1, A_RAT, 32'ha0);
    mode <= mode_fd_master;
    n = 0;
    xn = 0;
    dn = 0;
    repeat (400) begin
      @(posedge core_clk);
      if (fd_bit_tick === 1'b1) n++;
      if (xdclk_tick === 1'b1) xn++;
      if (dclk_tick === 1'b1) dn++;
    end
    chk("fd_range2", 0, n);
    chk("xdclk_cnt", 200, xn);
    chk("dclk_cnt", 400, dn);
    conclude();
  end
endmodule : test_rx_timing_config_registers
